// file: core/ispfc_top.sv
// isp flash command registers, sequencer and rom banking pin select
`timescale 1ns/1ns
`default_nettype none
module ispfc_top (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // special-function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // programming mode enable and idle request from other registers
    input wire logic programming_mode_enable_i,
    input wire logic idle_request_i,
    // cpu stall while a flash operation is running
    output logic cpu_hold_o,
    output logic true_idle_o,
    // flash array interface
    output logic flash_req_o,
    output ispfc_pkg::ispfc_cmd_t flash_cmd_o,
    output logic flash_loader_sel_o,
    output logic flash_bank_sel_o,
    output logic [15:0] flash_addr_o,
    output logic [7:0] flash_wdata_o,
    input wire logic flash_done_i,
    input wire logic [7:0] flash_rdata_i,
    // port-1 A16 override
    output logic [7:0] p1_a16_en_o,
    output logic p1_a16_o,
    // current code bank for fetches when banking is on
    input wire logic fetch_bank_i
);
    import ispfc_pkg::*;

    typedef enum logic [1:0] {
        ISPFC_IDLE,
        ISPFC_BUSY,
        ISPFC_TRUE_IDLE
    } ispfc_state_t;

    logic [7:0] rom_bank_control;
    logic [7:0] prog_addr_low;
    logic [7:0] prog_addr_high;
    logic [7:0] prog_data_buffer;
    logic [7:0] prog_operation_mode;
    logic [7:0] next_rom_bank_control;
    logic [7:0] next_prog_addr_low;
    logic [7:0] next_prog_addr_high;
    logic [7:0] next_prog_data_buffer;
    logic [7:0] next_prog_operation_mode;
    ispfc_state_t state;
    ispfc_state_t next_state;
    ispfc_cmd_t decoded_cmd;
    ispfc_cmd_t next_flash_cmd;
    logic next_flash_req;
    logic next_loader_sel;
    logic next_bank_sel;
    logic [15:0] next_flash_addr;
    logic [7:0] next_flash_wdata;
    logic next_cpu_hold;
    logic next_true_idle;
    logic [7:0] next_rdata;
    logic [7:0] next_a16_en;
    logic next_a16;

    // one-hot pin enable from the three-bit select
    function automatic logic [7:0] pin_onehot(input logic [2:0] sel);
        pin_onehot = 8'h01 << sel;
    endfunction

    ispfc_decode u_decode (
        .mode_i(prog_operation_mode),
        .cmd_o(decoded_cmd)
    );

    // register writes and the sequencer; flash read data wins the buffer
    always_comb begin
        next_rom_bank_control = rom_bank_control;
        next_prog_addr_low = prog_addr_low;
        next_prog_addr_high = prog_addr_high;
        next_prog_data_buffer = prog_data_buffer;
        next_prog_operation_mode = prog_operation_mode;
        next_state = state;
        next_flash_req = 1'b0;
        next_flash_cmd = flash_cmd_o;
        next_loader_sel = flash_loader_sel_o;
        next_bank_sel = flash_bank_sel_o;
        next_flash_addr = flash_addr_o;
        next_flash_wdata = flash_wdata_o;
        next_cpu_hold = cpu_hold_o;
        next_true_idle = true_idle_o;
        // cpu is stalled while busy, so writes are only honoured outside it
        if (sfr_wr_i && state != ISPFC_BUSY) begin
            unique case (sfr_addr_i)
                ROM_BANK_CONTROL_ADDR: next_rom_bank_control = {4'h0, sfr_wdata_i[3:0]};
                PROG_ADDR_LOW_ADDR: next_prog_addr_low = sfr_wdata_i;
                PROG_ADDR_HIGH_ADDR: next_prog_addr_high = sfr_wdata_i;
                PROG_DATA_BUFFER_ADDR: next_prog_data_buffer = sfr_wdata_i;
                PROG_OPERATION_MODE_ADDR: next_prog_operation_mode = sfr_wdata_i;
                default: ;
            endcase
        end
        unique case (state)
            ISPFC_IDLE: begin
                if (idle_request_i) begin
                    if (programming_mode_enable_i && decoded_cmd != ISPFC_CMD_NONE) begin
                        next_state = ISPFC_BUSY;
                        next_flash_req = 1'b1;
                        next_flash_cmd = decoded_cmd;
                        next_loader_sel = prog_operation_mode[MODE_TARGET_BIT];
                        next_bank_sel = prog_operation_mode[MODE_BANK_BIT];
                        // erase covers the whole array, so the address is don't-care
                        next_flash_addr = {prog_addr_high, prog_addr_low};
                        next_flash_wdata = prog_data_buffer;
                        next_cpu_hold = 1'b1;
                    end else if (!programming_mode_enable_i) begin
                        next_state = ISPFC_TRUE_IDLE;
                        next_true_idle = 1'b1;
                    end
                end
            end
            ISPFC_BUSY: begin
                if (flash_done_i) begin
                    if (flash_cmd_o == ISPFC_CMD_READ) begin
                        next_prog_data_buffer = flash_rdata_i;
                    end
                    next_state = ISPFC_IDLE;
                    next_cpu_hold = 1'b0;
                end
            end
            ISPFC_TRUE_IDLE: begin
                // wake-up belongs to the core; idle request drop releases it
                if (!idle_request_i) begin
                    next_state = ISPFC_IDLE;
                    next_true_idle = 1'b0;
                end
            end
        endcase
    end

    // read mux and A16 pin override
    always_comb begin
        unique case (sfr_addr_i)
            ROM_BANK_CONTROL_ADDR: next_rdata = rom_bank_control;
            PROG_ADDR_LOW_ADDR: next_rdata = prog_addr_low;
            PROG_ADDR_HIGH_ADDR: next_rdata = prog_addr_high;
            PROG_DATA_BUFFER_ADDR: next_rdata = next_prog_data_buffer;
            PROG_OPERATION_MODE_ADDR: next_rdata = prog_operation_mode;
            default: next_rdata = 8'h00;
        endcase
        if (rom_bank_control[ROM_EN_BIT]) begin
            next_a16_en = pin_onehot(rom_bank_control[ROM_PIN_MSB:0]);
            next_a16 = fetch_bank_i;
        end else begin
            next_a16_en = 8'h00;
            next_a16 = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rom_bank_control <= ROM_BANK_CONTROL_RST;
            prog_addr_low <= PROG_REG_RST;
            prog_addr_high <= PROG_REG_RST;
            prog_data_buffer <= PROG_REG_RST;
            prog_operation_mode <= PROG_REG_RST;
            state <= ISPFC_IDLE;
            flash_req_o <= 1'b0;
            flash_cmd_o <= ISPFC_CMD_NONE;
            flash_loader_sel_o <= 1'b0;
            flash_bank_sel_o <= 1'b0;
            flash_addr_o <= 16'h0000;
            flash_wdata_o <= 8'h00;
            cpu_hold_o <= 1'b0;
            true_idle_o <= 1'b0;
            sfr_rdata_o <= 8'h00;
            p1_a16_en_o <= 8'h00;
            p1_a16_o <= 1'b0;
        end else begin
            rom_bank_control <= next_rom_bank_control;
            prog_addr_low <= next_prog_addr_low;
            prog_addr_high <= next_prog_addr_high;
            prog_data_buffer <= next_prog_data_buffer;
            prog_operation_mode <= next_prog_operation_mode;
            state <= next_state;
            flash_req_o <= next_flash_req;
            flash_cmd_o <= next_flash_cmd;
            flash_loader_sel_o <= next_loader_sel;
            flash_bank_sel_o <= next_bank_sel;
            flash_addr_o <= next_flash_addr;
            flash_wdata_o <= next_flash_wdata;
            cpu_hold_o <= next_cpu_hold;
            true_idle_o <= next_true_idle;
            sfr_rdata_o <= next_rdata;
            p1_a16_en_o <= next_a16_en;
            p1_a16_o <= next_a16;
        end
    end
endmodule // ispfc_top
`default_nettype wire

// file: core/ispfc_pkg.sv
// shared constants for the isp flash command and banking block
package ispfc_pkg;
    localparam logic [7:0] ROM_BANK_CONTROL_ADDR = 8'hab;
    localparam logic [7:0] PROG_ADDR_LOW_ADDR = 8'hac;
    localparam logic [7:0] PROG_ADDR_HIGH_ADDR = 8'had;
    localparam logic [7:0] PROG_DATA_BUFFER_ADDR = 8'hae;
    localparam logic [7:0] PROG_OPERATION_MODE_ADDR = 8'haf;
    // operation-mode field positions
    localparam int MODE_BANK_BIT = 7;
    localparam int MODE_TARGET_BIT = 6;
    localparam int MODE_OE_LOW_BIT = 5;
    localparam int MODE_CE_LOW_BIT = 4;
    // rom bank control field positions
    localparam int ROM_EN_BIT = 3;
    localparam int ROM_PIN_MSB = 2;
    // operation codes
    localparam logic [3:0] OP_READ = 4'h0;
    localparam logic [3:0] OP_PROGRAM = 4'h1;
    localparam logic [3:0] OP_ERASE = 4'h2;
    // reset values
    localparam logic [7:0] ROM_BANK_CONTROL_RST = 8'h07;
    localparam logic [7:0] PROG_REG_RST = 8'h00;
    // flash command kinds
    typedef enum logic [1:0] {
        ISPFC_CMD_READ,
        ISPFC_CMD_PROGRAM,
        ISPFC_CMD_ERASE,
        ISPFC_CMD_NONE
    } ispfc_cmd_t;
endpackage

// file: core/ispfc_decode.sv
// decodes the operation-mode byte into a flash command
`timescale 1ns/1ns
`default_nettype none
module ispfc_decode (
    input wire logic [7:0] mode_i,
    output ispfc_pkg::ispfc_cmd_t cmd_o
);
    import ispfc_pkg::*;

    // only the exact enable and code pairs are legal; anything else does nothing
    always_comb begin
        cmd_o = ISPFC_CMD_NONE;
        if (mode_i[MODE_CE_LOW_BIT] == 1'b0) begin
            if (mode_i[MODE_OE_LOW_BIT] && mode_i[3:0] == OP_ERASE) begin
                cmd_o = ISPFC_CMD_ERASE;
            end else if (mode_i[MODE_OE_LOW_BIT] && mode_i[3:0] == OP_PROGRAM) begin
                cmd_o = ISPFC_CMD_PROGRAM;
            end else if (!mode_i[MODE_OE_LOW_BIT] && mode_i[3:0] == OP_READ) begin
                cmd_o = ISPFC_CMD_READ;
            end
        end
    end
endmodule // ispfc_decode
`default_nettype wire

// file: tb/ispfc_checker.sv
// concurrent checks on the isp flash command block ports
`timescale 1ns/1ns
`default_nettype none
module ispfc_checker (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic programming_mode_enable_i,
    input wire logic idle_request_i,
    input wire logic cpu_hold_o,
    input wire logic true_idle_o,
    input wire logic flash_req_o,
    input wire ispfc_pkg::ispfc_cmd_t flash_cmd_o,
    input wire logic [15:0] flash_addr_o,
    input wire logic flash_done_i,
    input wire logic [7:0] p1_a16_en_o,
    input wire logic p1_a16_o,
    input wire logic fetch_bank_i
);
    import ispfc_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // a start needs an idle request while programming mode is on
    property p_go; flash_req_o |-> $past(idle_request_i) && $past(programming_mode_enable_i);
    endproperty
    a_go: assert property (p_go) else $error("start without request");
    property p_pulse; flash_req_o |-> cpu_hold_o ##1 !flash_req_o; endproperty
    a_pulse: assert property (p_pulse) else $error("start not a held pulse");
    property p_legal; flash_req_o |-> flash_cmd_o != ISPFC_CMD_NONE; endproperty
    a_legal: assert property (p_legal) else $error("start with no command");
    // target must not move under a running operation
    property p_keep; cpu_hold_o && !flash_req_o |-> $stable(flash_addr_o) && $stable(flash_cmd_o);
    endproperty
    a_keep: assert property (p_keep) else $error("target moved while busy");
    property p_done; cpu_hold_o && flash_done_i |=> !cpu_hold_o; endproperty
    a_done: assert property (p_done) else $error("cpu not resumed");
    property p_idle; idle_request_i && !programming_mode_enable_i && !cpu_hold_o |=> true_idle_o;
    endproperty
    a_idle: assert property (p_idle) else $error("true idle not entered");
    // a16 pin: one-hot select, level one cycle behind the fetch bank
    property p_a16; p1_a16_en_o != 8'h00 |-> $onehot(p1_a16_en_o) && p1_a16_o == $past(fetch_bank_i);
    endproperty
    a_a16: assert property (p_a16) else $error("a16 pin wrong");
    property p_a16off; p1_a16_en_o == 8'h00 |-> !p1_a16_o; endproperty
    a_a16off: assert property (p_a16off) else $error("a16 driven while off");
    c_read: cover property (flash_req_o && flash_cmd_o == ISPFC_CMD_READ);
    c_erase: cover property (flash_req_o && flash_cmd_o == ISPFC_CMD_ERASE);
    c_idle: cover property (true_idle_o);
endmodule // ispfc_checker
bind ispfc_top ispfc_checker u_chk (.*);
`default_nettype wire

// file: tb/ispfc_flash_model.sv
// behavioural flash arrays behind the isp sequencer
`timescale 1ns/1ns
`default_nettype none
module ispfc_flash_model #(
    parameter logic [7:0] ERASED = 8'hff // blank byte; the bench expects 8'hff on read-back
) (
    input wire logic clk_i,
    input wire logic req_i,
    input wire ispfc_pkg::ispfc_cmd_t cmd_i,
    input wire logic loader_i,
    input wire logic bank_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic done_o,
    output logic [7:0] rdata_o
);
    import ispfc_pkg::*;
    logic [7:0] mem [3][int];
    logic [7:0] val = 8'h00;
    logic slow = 1'b0;
    int cnt = -1;
    int r;
    initial done_o = 1'b0;
    initial rdata_o = 8'h00;
    // fast and slow answers in turn; read data churns outside the done cycle
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (cnt > 0) cnt--;
        else if (cnt == 0) begin
            done_o <= 1'b1;
            rdata_o <= val;
            cnt = -1;
        end else if (req_i) begin
            r = loader_i ? 2 : int'(bank_i);
            if (cmd_i == ISPFC_CMD_ERASE) mem[r].delete();
            if (cmd_i == ISPFC_CMD_PROGRAM) mem[r][addr_i] = wdata_i;
            val = mem[r].exists(addr_i) ? mem[r][addr_i] : ERASED;
            cnt = slow ? 6 : 0;
            slow = ~slow;
        end
    end
endmodule // ispfc_flash_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the isp flash command block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ispfc_pkg::*;
    logic clk = 0, srst = 1, wr = 0, pme = 0, idle = 0, fb = 0, rd_v = 0, rd_q = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, a16en, fwd, frd, v;
    logic hold, tidle, req, lsel, bsel, done, a16;
    logic [15:0] faddr, a;
    logic [27:0] e, m;
    logic [7:0] d [3];
    logic [7:0] q_rd [$];
    logic [27:0] q_op [$];
    ispfc_cmd_t cmd;
    int fail_count = 0, n_checks = 0;
    ispfc_top dut (.sys_clk_i(clk), .srst_i(srst), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .programming_mode_enable_i(pme),
        .idle_request_i(idle), .cpu_hold_o(hold), .true_idle_o(tidle), .flash_req_o(req),
        .flash_cmd_o(cmd), .flash_loader_sel_o(lsel), .flash_bank_sel_o(bsel),
        .flash_addr_o(faddr), .flash_wdata_o(fwd), .flash_done_i(done),
        .flash_rdata_i(frd), .p1_a16_en_o(a16en), .p1_a16_o(a16), .fetch_bank_i(fb));
    ispfc_flash_model u_flash (.clk_i(clk), .req_i(req), .cmd_i(cmd), .loader_i(lsel),
        .bank_i(bsel), .addr_i(faddr), .wdata_i(fwd), .done_o(done), .rdata_o(frd));
    initial forever #10 clk = ~clk;
    task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // register cycles: one-cycle write strobe, read noted for the watcher
    task automatic wr_reg(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk);
        #1 addr = ad;
        wdata = dt;
        wr = 1;
        @(posedge clk);
        #1 wr = 0;
    endtask
    task automatic rd_reg(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk);
        #1 addr = ad;
        rd_v = 1;
        q_rd.push_back(exp);
        @(posedge clk);
        #1 rd_v = 0;
    endtask
    // idle request is dropped once busy, else the op would restart
    task automatic op(input int r, input ispfc_cmd_t c, input logic [15:0] ad, input logic [7:0] dt);
        wr_reg(PROG_ADDR_LOW_ADDR, ad[7:0]);
        wr_reg(PROG_ADDR_HIGH_ADDR, ad[15:8]);
        wr_reg(PROG_DATA_BUFFER_ADDR, dt);
        wr_reg(PROG_OPERATION_MODE_ADDR, {r == 1, r == 2, c != ISPFC_CMD_READ, 3'b000, c});
        q_op.push_back({c, r == 2, r == 1, ad, dt});
        #1 idle = 1;
        for (int k = 0; k < 20 && hold !== 1'b1; k++) @(posedge clk);
        #1 idle = 0;
        for (int k = 0; k < 20 && hold !== 1'b0; k++) @(posedge clk);
        check("hold released", 28'(hold), 28'h0);
    endtask
    // watcher: oldest note against each read result and each flash start
    always @(posedge clk) begin
        rd_q <= rd_v;
        if (rd_q) check("sfr read", 28'(rdata), 28'(q_rd.pop_front()));
        if (req) begin
            e = q_op.pop_front();
            m = (e[27:26] == ISPFC_CMD_ERASE) ? 28'hf000000 : 28'hfffffff;
            check("flash start", {cmd, lsel, bsel, faddr, fwd} & m, e & m);
        end
    end
    initial begin
        void'($urandom(68877));
        repeat (2) @(posedge clk);
        #1 srst = 0;
        rd_reg(ROM_BANK_CONTROL_ADDR, ROM_BANK_CONTROL_RST);
        for (int i = 'hac; i <= 'hb0; i++) rd_reg(8'(i), 8'h00);
        for (int i = 'hab; i <= 'haf; i++) begin
            v = 8'($urandom);
            wr_reg(8'(i), v);
            rd_reg(8'(i), i == 'hab ? v & 8'h0f : v);
        end
        pme = 1;
        a = 16'($urandom);
        for (int r = 0; r < 3; r++) op(r, ISPFC_CMD_ERASE, a, 8'h00);
        for (int r = 0; r < 3; r++) begin
            d[r] = 8'($urandom);
            op(r, ISPFC_CMD_PROGRAM, a, d[r]);
        end
        for (int r = 0; r < 3; r++) begin
            op(r, ISPFC_CMD_READ, a, 8'h00);
            rd_reg(PROG_DATA_BUFFER_ADDR, d[r]);
            op(r, ISPFC_CMD_READ, a ^ 16'h0001, 8'h00);
            rd_reg(PROG_DATA_BUFFER_ADDR, 8'hff);
        end
        // reserved code is refused; with programming off the request idles
        wr_reg(PROG_OPERATION_MODE_ADDR, 8'h13);
        #1 idle = 1;
        repeat (4) @(posedge clk);
        check("refused start", 28'(hold), 28'h0);
        #1 pme = 0;
        repeat (2) @(posedge clk);
        check("true idle", 28'(tidle), 28'h1);
        #1 idle = 0;
        for (int n = 0; n < 9; n++) begin
            wr_reg(ROM_BANK_CONTROL_ADDR, n < 8 ? 8'(8 + n) : 8'h07);
            fb = 1'($urandom);
            repeat (2) @(posedge clk);
            check("a16 pins", 28'({a16en, a16}), n < 8 ? 28'({8'(8'h01 << n), fb}) : 28'h0);
        end
        close_out();
    end
    // watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule // testbench
`default_nettype wire
